// *** inc/usb_ep0_pkg.sv ***
/*
  Constants, register map and enumerations for the endpoint-0 control block.
  Assumes a 32-bit APB slave port and a single 25 MHz clock.
*/
// Operation
// R1 - setup arrival sets flag, raises interrupt
// R2 - in tokens get nak while flag set
// R3 - flag clear mid-token keeps one clean answer
// R4 - inactive endpoint gates in-flight token handling
// R5 - core off resets function logic
// R6 - software stalls unsupported or failed requests
// R7 - next setup clears endpoint stall
// R8 - stall clear waits for config access
// R9 - bus reset resets logic when enabled
// R10 - control writes ignored during bus reset when enabled
// R11 - software locks registers with zero key
// R12 - pll flags raised until pll stable
// R13 - bus reset sets interrupt flag
package usb_ep0_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_CORE_CTRL = 12'h000;
  localparam logic [11:0] OFS_EP0_IN = 12'h004;
  localparam logic [11:0] OFS_EP0_OUT = 12'h008;
  localparam logic [11:0] OFS_IRQ_STAT = 12'h00C;
  localparam logic [11:0] OFS_IRQ_MASK = 12'h010;
  localparam logic [11:0] OFS_PLL_CTRL = 12'h014;
  localparam logic [11:0] OFS_PLL_STAT = 12'h018;
  localparam logic [11:0] OFS_KEY = 12'h01C;

  // ----------------------------------------------------------------
  // register indices after decode
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    IDX_CORE_CTRL,
    IDX_EP0_IN,
    IDX_EP0_OUT,
    IDX_IRQ_STAT,
    IDX_IRQ_MASK,
    IDX_PLL_CTRL,
    IDX_PLL_STAT,
    IDX_KEY,
    IDX_NONE
  } reg_idx_t;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTRL_CORE_ON = 0;
  localparam int CTRL_FUNC_RST_EN = 1;
  localparam int EPCFG_ACTIVE = 0;
  localparam int EPCFG_STALL = 3;
  localparam int STAT_SETUP = 0;
  localparam int STAT_BUS_RST = 1;
  localparam int STAT_IN_DONE = 2;
  localparam int STAT_W = 3;
  localparam int PLL_EN = 0;
  localparam int PLL_FLAG = 0;

  // ----------------------------------------------------------------
  // reset values and key
  // ----------------------------------------------------------------
  localparam logic [STAT_W-1:0] MASK_RESET = 3'h0;
  // unlock key value is arbitrary
  localparam logic [31:0] UNLOCK_KEY = 32'h0000A5A5;

  // ----------------------------------------------------------------
  // timing: pll must show lock this long before flags stop
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 25;
  localparam int PLL_SETTLE_US = 16;
  localparam int PLL_SETTLE_CYC = PLL_SETTLE_US * CLK_MHZ;
  localparam int SETTLE_W = 9;

  // handshake chosen for an in token
  typedef enum logic [1:0] {
    ANS_DATA,
    ANS_NAK,
    ANS_STALL
  } ans_t;

endpackage

// *** rtl/usb_sync2.sv ***
/*
  Two-stage synchroniser for one level arriving from outside the clock domain.
  Assumes the level is slow against clock_i.
*/
`timescale 1ns/1ps
module usb_sync2 (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic async_i,
  output logic sync_o
);

  logic meta_q;
  logic meta_d;
  logic sync_q;

  // first stage feeds only the second
  always_comb
  begin
    meta_d = async_i;
  end

  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;

endmodule

// *** rtl/usb_pll_settle.sv ***
/*
  Watches the synchronised pll lock level and reports instability until the
  lock has held for the settle time. Assumes lock_i is already synchronised.
*/
`timescale 1ns/1ps
module usb_pll_settle (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic enable_i,
  input wire logic lock_i,
  output logic unstable_o
);

  logic [usb_ep0_pkg::SETTLE_W-1:0] cnt_q;
  logic [usb_ep0_pkg::SETTLE_W-1:0] cnt_d;
  logic unstable_q;
  logic unstable_d;

  // any loss of lock restarts the count, so a glitchy pll keeps flagging
  always_comb
  begin
    cnt_d = cnt_q;
    unstable_d = 1'b0;
    if (!enable_i || !lock_i)
    begin
      cnt_d = '0;
      unstable_d = enable_i;
    end
    else if (cnt_q != usb_ep0_pkg::SETTLE_W'(usb_ep0_pkg::PLL_SETTLE_CYC))
    begin
      cnt_d = cnt_q + 1'b1;
      unstable_d = 1'b1;
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      cnt_q <= '0;
      unstable_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      unstable_q <= unstable_d;
    end
  end

  assign unstable_o = unstable_q;

endmodule

// *** rtl/usb_ep0_ctrl.sv ***
/*
  Endpoint-0 control-transfer, stall, bus-reset and pll-flag logic with an
  APB register slave. Assumes a packet decoder on clock_i delivering setup and
  in-token pulses, and bus reset and pll lock as asynchronous levels.
*/
`timescale 1ns/1ps
module usb_ep0_ctrl (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic setup_rx_i,
  input wire logic in_tok_start_i,
  input wire logic in_tok_end_i,
  input wire logic bus_reset_i,
  input wire logic pll_lock_i,
  output logic in_data_o,
  output logic in_nak_o,
  output logic in_stall_o,
  output logic core_rst_o,
  output logic pll_en_o,
  output logic irq_o
);

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  function automatic usb_ep0_pkg::reg_idx_t decode(input logic [11:0] a);
    if (a == usb_ep0_pkg::OFS_CORE_CTRL) return usb_ep0_pkg::IDX_CORE_CTRL;
    else if (a == usb_ep0_pkg::OFS_EP0_IN) return usb_ep0_pkg::IDX_EP0_IN;
    else if (a == usb_ep0_pkg::OFS_EP0_OUT) return usb_ep0_pkg::IDX_EP0_OUT;
    else if (a == usb_ep0_pkg::OFS_IRQ_STAT) return usb_ep0_pkg::IDX_IRQ_STAT;
    else if (a == usb_ep0_pkg::OFS_IRQ_MASK) return usb_ep0_pkg::IDX_IRQ_MASK;
    else if (a == usb_ep0_pkg::OFS_PLL_CTRL) return usb_ep0_pkg::IDX_PLL_CTRL;
    else if (a == usb_ep0_pkg::OFS_PLL_STAT) return usb_ep0_pkg::IDX_PLL_STAT;
    else if (a == usb_ep0_pkg::OFS_KEY) return usb_ep0_pkg::IDX_KEY;
    else return usb_ep0_pkg::IDX_NONE;
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic core_on_q, core_on_d, fre_q, fre_d, stall_pend_q, stall_pend_d, tok_busy_q, tok_busy_d;
  logic [1:0] ep_act_q, ep_act_d, stall_q, stall_d;
  logic [usb_ep0_pkg::STAT_W-1:0] stat_q, stat_d, mask_q, mask_d;
  logic pll_en_q, pll_en_d, pll_flag_q, pll_flag_d, unlocked_q, unlocked_d, brst_prev_q, brst_prev_d;
  usb_ep0_pkg::ans_t tok_ans_q, tok_ans_d;
  logic data_q, data_d, nak_q, nak_d, stl_q, stl_d, irq_q, irq_d, core_rst_q, core_rst_d;
  logic pready_q, pready_d, pslverr_q, pslverr_d;
  logic [31:0] prdata_q, prdata_d;
  logic bus_rst_s, pll_lock_s, pll_unstable, func_rst, wr_en, cfg_access, wr_ok, bus_rst_edge;
  usb_ep0_pkg::reg_idx_t idx;

  // external levels cross into the clock domain
  usb_sync2 u_sync_brst (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .async_i(bus_reset_i), .sync_o(bus_rst_s));
  usb_sync2 u_sync_lock (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .async_i(pll_lock_i), .sync_o(pll_lock_s));
  // R12 - pll settle watch
  usb_pll_settle u_settle (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .enable_i(pll_en_q), .lock_i(pll_lock_s),
    .unstable_o(pll_unstable));

  // ----------------------------------------------------------------
  // shared terms
  // ----------------------------------------------------------------
  // R5 - core off resets
  // R9 - host reset resets
  assign func_rst = !core_on_q || (fre_q && bus_rst_s);
  assign idx = decode(paddr_i);
  assign wr_en = psel_i && penable_i && pwrite_i && pready_q;
  // a config access spans setup and access phase of the transfer
  assign cfg_access = psel_i && (idx == usb_ep0_pkg::IDX_EP0_IN || idx == usb_ep0_pkg::IDX_EP0_OUT);
  assign bus_rst_edge = bus_rst_s && !brst_prev_q;

  // R10 - block control writes
  // locked registers, and control registers under bus reset with function reset enabled, drop writes silently
  always_comb
  begin
    wr_ok = wr_en && (unlocked_q || idx == usb_ep0_pkg::IDX_KEY);
    if (fre_q && bus_rst_s && (idx == usb_ep0_pkg::IDX_CORE_CTRL || idx == usb_ep0_pkg::IDX_EP0_IN
        || idx == usb_ep0_pkg::IDX_EP0_OUT || idx == usb_ep0_pkg::IDX_PLL_CTRL))
      wr_ok = 1'b0;
  end

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    core_on_d = core_on_q;
    fre_d = fre_q;
    ep_act_d = ep_act_q;
    stall_d = stall_q;
    stall_pend_d = stall_pend_q;
    stat_d = stat_q;
    mask_d = mask_q;
    pll_en_d = pll_en_q;
    pll_flag_d = pll_flag_q;
    unlocked_d = unlocked_q;
    tok_busy_d = tok_busy_q;
    tok_ans_d = tok_ans_q;
    data_d = 1'b0;
    nak_d = 1'b0;
    stl_d = 1'b0;
    brst_prev_d = bus_rst_s;
    // software writes first, hardware events override below
    if (wr_ok)
    begin
      case (idx)
        usb_ep0_pkg::IDX_CORE_CTRL:
        begin
          core_on_d = pwdata_i[usb_ep0_pkg::CTRL_CORE_ON];
          fre_d = pwdata_i[usb_ep0_pkg::CTRL_FUNC_RST_EN];
        end
        usb_ep0_pkg::IDX_EP0_IN:
        begin
          ep_act_d[0] = pwdata_i[usb_ep0_pkg::EPCFG_ACTIVE];
          stall_d[0] = pwdata_i[usb_ep0_pkg::EPCFG_STALL];
        end
        usb_ep0_pkg::IDX_EP0_OUT:
        begin
          ep_act_d[1] = pwdata_i[usb_ep0_pkg::EPCFG_ACTIVE];
          stall_d[1] = pwdata_i[usb_ep0_pkg::EPCFG_STALL];
        end
        usb_ep0_pkg::IDX_IRQ_STAT: stat_d = stat_q & ~pwdata_i[usb_ep0_pkg::STAT_W-1:0];
        usb_ep0_pkg::IDX_IRQ_MASK: mask_d = pwdata_i[usb_ep0_pkg::STAT_W-1:0];
        usb_ep0_pkg::IDX_PLL_CTRL: pll_en_d = pwdata_i[usb_ep0_pkg::PLL_EN];
        usb_ep0_pkg::IDX_PLL_STAT: pll_flag_d = 1'b0;
        // R11 - any value but the key locks
        usb_ep0_pkg::IDX_KEY: unlocked_d = (pwdata_i == usb_ep0_pkg::UNLOCK_KEY);
        default: unlocked_d = unlocked_q;
      endcase
    end
    // R12 - flag set wins
    if (pll_unstable) pll_flag_d = 1'b1;
    // R13 - bus reset flag
    if (bus_rst_edge) stat_d[usb_ep0_pkg::STAT_BUS_RST] = 1'b1;
    if (func_rst)
    begin
      // R9 - wipe function state
      ep_act_d = 2'b00;
      stall_d = 2'b00;
      stall_pend_d = 1'b0;
      tok_busy_d = 1'b0;
      tok_ans_d = usb_ep0_pkg::ANS_DATA;
      stat_d[usb_ep0_pkg::STAT_SETUP] = 1'b0;
    end
    else
    begin
      // R8 - deferred clear after access
      if (stall_pend_q && !cfg_access)
      begin
        stall_d = 2'b00;
        stall_pend_d = 1'b0;
      end
      if (setup_rx_i)
      begin
        // R1 - setup sets flag
        stat_d[usb_ep0_pkg::STAT_SETUP] = 1'b1;
        // R7 - setup clears stall
        if (cfg_access) stall_pend_d = 1'b1;
        else stall_d = 2'b00;
      end
      // R3 - decision frozen at token start
      // a flag clear in the crc bits cannot change the answer in flight
      if (in_tok_start_i)
      begin
        tok_busy_d = 1'b1;
        // R2 - nak while pending
        if (stat_q[usb_ep0_pkg::STAT_SETUP]) tok_ans_d = usb_ep0_pkg::ANS_NAK;
        else if (stall_q[0]) tok_ans_d = usb_ep0_pkg::ANS_STALL;
        else tok_ans_d = usb_ep0_pkg::ANS_DATA;
      end
      else if (in_tok_end_i && tok_busy_q)
      begin
        tok_busy_d = 1'b0;
        // R4 - inactive endpoint orphans token
        if (ep_act_q[0])
        begin
          case (tok_ans_q)
            usb_ep0_pkg::ANS_NAK: nak_d = 1'b1;
            usb_ep0_pkg::ANS_STALL: stl_d = 1'b1;
            default:
            begin
              data_d = 1'b1;
              stat_d[usb_ep0_pkg::STAT_IN_DONE] = 1'b1;
            end
          endcase
        end
      end
    end
    irq_d = |(stat_d & mask_d);
    core_rst_d = !core_on_d || (fre_d && bus_rst_s);
  end

  // ----------------------------------------------------------------
  // apb answer: data prepared in setup phase, ready in access phase
  // ----------------------------------------------------------------
  always_comb
  begin
    pready_d = psel_i && !penable_i;
    pslverr_d = psel_i && !penable_i && (idx == usb_ep0_pkg::IDX_NONE);
    prdata_d = 32'h00000000;
    if (psel_i && !penable_i && !pwrite_i)
    begin
      if (idx == usb_ep0_pkg::IDX_CORE_CTRL)
      begin
        prdata_d[usb_ep0_pkg::CTRL_CORE_ON] = core_on_q;
        prdata_d[usb_ep0_pkg::CTRL_FUNC_RST_EN] = fre_q;
      end
      else if (idx == usb_ep0_pkg::IDX_EP0_IN)
      begin
        prdata_d[usb_ep0_pkg::EPCFG_ACTIVE] = ep_act_q[0];
        prdata_d[usb_ep0_pkg::EPCFG_STALL] = stall_q[0];
      end
      else if (idx == usb_ep0_pkg::IDX_EP0_OUT)
      begin
        prdata_d[usb_ep0_pkg::EPCFG_ACTIVE] = ep_act_q[1];
        prdata_d[usb_ep0_pkg::EPCFG_STALL] = stall_q[1];
      end
      else if (idx == usb_ep0_pkg::IDX_IRQ_STAT) prdata_d[usb_ep0_pkg::STAT_W-1:0] = stat_q;
      else if (idx == usb_ep0_pkg::IDX_IRQ_MASK) prdata_d[usb_ep0_pkg::STAT_W-1:0] = mask_q;
      else if (idx == usb_ep0_pkg::IDX_PLL_CTRL) prdata_d[usb_ep0_pkg::PLL_EN] = pll_en_q;
      else if (idx == usb_ep0_pkg::IDX_PLL_STAT) prdata_d[usb_ep0_pkg::PLL_FLAG] = pll_flag_q;
      else if (idx == usb_ep0_pkg::IDX_KEY) prdata_d[0] = unlocked_q;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      core_on_q <= 1'b0;
      fre_q <= 1'b0;
      ep_act_q <= 2'b00;
      stall_q <= 2'b00;
      stall_pend_q <= 1'b0;
      stat_q <= '0;
      mask_q <= usb_ep0_pkg::MASK_RESET;
      pll_en_q <= 1'b0;
      pll_flag_q <= 1'b0;
      unlocked_q <= 1'b0;
      tok_busy_q <= 1'b0;
      tok_ans_q <= usb_ep0_pkg::ANS_DATA;
      brst_prev_q <= 1'b0;
      data_q <= 1'b0;
      nak_q <= 1'b0;
      stl_q <= 1'b0;
      irq_q <= 1'b0;
      core_rst_q <= 1'b1;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end
    else
    begin
      core_on_q <= core_on_d;
      fre_q <= fre_d;
      ep_act_q <= ep_act_d;
      stall_q <= stall_d;
      stall_pend_q <= stall_pend_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
      pll_en_q <= pll_en_d;
      pll_flag_q <= pll_flag_d;
      unlocked_q <= unlocked_d;
      tok_busy_q <= tok_busy_d;
      tok_ans_q <= tok_ans_d;
      brst_prev_q <= brst_prev_d;
      data_q <= data_d;
      nak_q <= nak_d;
      stl_q <= stl_d;
      irq_q <= irq_d;
      core_rst_q <= core_rst_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
    end
  end

  assign prdata_o = prdata_q;
  assign pready_o = pready_q;
  assign pslverr_o = pslverr_q;
  assign in_data_o = data_q;
  assign in_nak_o = nak_q;
  assign in_stall_o = stl_q;
  assign core_rst_o = core_rst_q;
  assign pll_en_o = pll_en_q;
  assign irq_o = irq_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);

  setup_flag_set_a: assert property (setup_rx_i && !func_rst |=> stat_q[0] && (irq_o || !mask_q[0])) // R1
    else $error("setup flag not set");
  nak_pending_a: assert property (in_tok_start_i && stat_q[0] && !func_rst ##1 !in_tok_start_i
    && in_tok_end_i && ep_act_q[0] && !func_rst |=> in_nak_o && !in_data_o) // R2
    else $error("in token not nakked");
  one_answer_a: assert property ((in_nak_o || in_data_o || in_stall_o) |-> $onehot({in_nak_o, in_data_o, in_stall_o})
    ##1 !(in_nak_o || in_data_o || in_stall_o)) // R3
    else $error("answer not single");
  orphan_token_a: assert property (in_tok_end_i && !ep_act_q[0] |=> !(in_nak_o || in_data_o || in_stall_o)) // R4
    else $error("inactive endpoint answered");
  core_off_a: assert property (!core_on_q |-> core_rst_o ##1 !tok_busy_q) // R5
    else $error("core off without reset");
  stall_clear_a: assert property (setup_rx_i && !func_rst && !cfg_access |=> stall_q == 2'b00) // R7
    else $error("stall not cleared");
  stall_defer_a: assert property (setup_rx_i && !func_rst && cfg_access && stall_q[0] && !wr_en
    |=> stall_q[0] && stall_pend_q) // R8
    else $error("stall clear not deferred");
  func_reset_a: assert property (fre_q && bus_rst_s |=> core_rst_o && stall_q == 2'b00 && !tok_busy_q) // R9
    else $error("bus reset did not reset");
  ctrl_locked_a: assert property (wr_en && fre_q && bus_rst_s && idx == usb_ep0_pkg::IDX_CORE_CTRL
    |=> $stable(core_on_q) && $stable(fre_q)) // R10
    else $error("control written during bus reset");
  pll_flag_a: assert property (pll_unstable |=> pll_flag_q) // R12
    else $error("pll flag not raised");
  brst_flag_a: assert property (bus_rst_s && !brst_prev_q |=> stat_q[1]) // R13
    else $error("bus reset flag missing");

  setup_then_nak_c: cover property (setup_rx_i ##[1:20] in_nak_o);
  deferred_stall_c: cover property (stall_pend_q ##[1:10] !stall_pend_q);
  data_sent_c: cover property (in_data_o);
  bus_reset_c: cover property (fre_q && bus_rst_edge);

endmodule

// *** test/usb_host_model.sv ***
/*
  Behavioural host plus packet decoder: setup and in-token pulses, bus reset
  and pll lock levels. Assumes it shares clock_i with the block under test.
*/
`timescale 1ns/1ps
module usb_host_model (
  input wire logic clock_i,
  input wire logic in_data_i,
  input wire logic in_nak_i,
  input wire logic in_stall_i,
  output logic setup_rx_o,
  output logic in_tok_start_o,
  output logic in_tok_end_o,
  output logic bus_reset_o,
  output logic pll_lock_o
);
  // quiet bus, pll not locked
  initial
  begin
    setup_rx_o = 1'b0;
    in_tok_start_o = 1'b0;
    in_tok_end_o = 1'b0;
    bus_reset_o = 1'b0;
    pll_lock_o = 1'b0;
  end

  // setup packet as a one-cycle pulse
  task automatic send_setup();
  begin
    @(posedge clock_i);
    setup_rx_o <= 1'b1;
    @(posedge clock_i);
    setup_rx_o <= 1'b0;
  end
  endtask

  // in token, gap idle cycles before the end; seen = {stall, nak, data}
  task automatic send_in(input int gap, output logic [2:0] seen);
  begin
    seen = 3'h0;
    @(posedge clock_i);
    in_tok_start_o <= 1'b1;
    @(posedge clock_i);
    in_tok_start_o <= 1'b0;
    repeat (gap) @(posedge clock_i);
    in_tok_end_o <= 1'b1;
    @(posedge clock_i);
    in_tok_end_o <= 1'b0;
    // window wider than the answer delay so a late answer still shows
    repeat (4)
    begin
      #1;
      seen = seen | {in_stall_i, in_nak_i, in_data_i};
      @(posedge clock_i);
    end
  end
  endtask

  // levels change just after an edge, like the pulses
  task automatic set_bus_reset(input logic v);
  begin
    @(posedge clock_i);
    bus_reset_o <= v;
  end
  endtask

  task automatic set_lock(input logic v);
  begin
    @(posedge clock_i);
    pll_lock_o <= v;
  end
  endtask
endmodule

// *** test/usb_endpoint0_control_logic_tb.sv ***
/*
  Self-checking bench for the endpoint-0 control block: APB master tasks and a
  host model. Assumes zero or more wait states and the package register map.
*/
`timescale 1ns/1ps
module usb_endpoint0_control_logic_tb;
  logic clock_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, setup_rx, tok_start, tok_end, bus_reset, pll_lock;
  logic in_data, in_nak, in_stall, core_rst, pll_en, irq;
  logic [31:0] rdata;
  logic err;
  logic [2:0] seen;
  int err_total = 0;
  int compares = 0;

  // 25 MHz clock
  always #20 clock_i = ~clock_i;

  usb_ep0_ctrl dut_u (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .setup_rx_i(setup_rx), .in_tok_start_i(tok_start), .in_tok_end_i(tok_end),
    .bus_reset_i(bus_reset), .pll_lock_i(pll_lock), .in_data_o(in_data), .in_nak_o(in_nak),
    .in_stall_o(in_stall), .core_rst_o(core_rst), .pll_en_o(pll_en), .irq_o(irq));

  usb_host_model host_u (.clock_i(clock_i), .in_data_i(in_data), .in_nak_i(in_nak), .in_stall_i(in_stall),
    .setup_rx_o(setup_rx), .in_tok_start_o(tok_start), .in_tok_end_o(tok_end), .bus_reset_o(bus_reset),
    .pll_lock_o(pll_lock));

  // --------------------------------------------------------------
  // checking and apb tasks
  // --------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
  begin
    compares++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected %s exp %h got %h", what, exp, got);
    end
  end
  endtask

  // one idle edge first, so psel is never driven twice in one step
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
  begin
    @(posedge clock_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clock_i);
    penable <= 1'b1;
    // only the watchdog ends a wait for ready
    do
    begin
      @(posedge clock_i);
    end
    while (pready !== 1'b1);
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  end
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input string what);
  begin
    apb(1'b0, a, 32'h0);
    chk(what, exp, rdata);
  end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
  begin
    apb(1'b1, a, d);
    // let registered outputs settle before a level check
    #1;
  end
  endtask

  task automatic tok(input int gap, input logic [2:0] exp);
  begin
    host_u.send_in(gap, seen);
    chk("handshake", {29'h0, exp}, {29'h0, seen});
  end
  endtask

  task automatic print_verdict();
  begin
    if (err_total == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  end
  endtask

  // watchdog well beyond the several hundred cycles of the sequence
  initial
  begin
    repeat (20000) @(posedge clock_i);
    err_total++;
    print_verdict();
  end

  // --------------------------------------------------------------
  // test sequence
  // --------------------------------------------------------------
  initial
  begin
    repeat (3) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    chk("core_rst", 32'h1, {31'h0, core_rst});
    rdc(usb_ep0_pkg::OFS_KEY, 32'h0, "key");
    wr(usb_ep0_pkg::OFS_CORE_CTRL, 32'h1);
    rdc(usb_ep0_pkg::OFS_CORE_CTRL, 32'h0, "locked ctrl");
    wr(usb_ep0_pkg::OFS_KEY, usb_ep0_pkg::UNLOCK_KEY);
    rdc(usb_ep0_pkg::OFS_KEY, 32'h1, "key");
    rdc(12'h020, 32'h0, "unmapped");
    chk("pslverr", 32'h1, {31'h0, err});
    wr(usb_ep0_pkg::OFS_CORE_CTRL, 32'h1);
    wr(usb_ep0_pkg::OFS_IRQ_MASK, 32'h7);
    wr(usb_ep0_pkg::OFS_EP0_IN, 32'h1);
    wr(usb_ep0_pkg::OFS_EP0_OUT, 32'h1);
    chk("core_rst", 32'h0, {31'h0, core_rst});
    host_u.send_setup();
    rdc(usb_ep0_pkg::OFS_IRQ_STAT, 32'h1, "status");
    chk("irq", 32'h1, {31'h0, irq});
    wr(usb_ep0_pkg::OFS_IRQ_MASK, 32'h0);
    chk("masked irq", 32'h0, {31'h0, irq});
    wr(usb_ep0_pkg::OFS_IRQ_MASK, 32'h7);
    tok(0, 3'b010);
    // flag cleared while a token is in flight: that token still gets nak
    fork
      tok(6, 3'b010);
      wr(usb_ep0_pkg::OFS_IRQ_STAT, 32'h1);
    join
    tok(2, 3'b001);
    wr(usb_ep0_pkg::OFS_IRQ_STAT, 32'h7);
    chk("irq idle", 32'h0, {31'h0, irq});
    wr(usb_ep0_pkg::OFS_EP0_IN, 32'h9);
    tok(1, 3'b100);
    host_u.send_setup();
    rdc(usb_ep0_pkg::OFS_EP0_IN, 32'h1, "stall cleared");
    // setup arriving during a config access: clear lands afterwards
    wr(usb_ep0_pkg::OFS_EP0_IN, 32'h9);
    fork
      apb(1'b0, usb_ep0_pkg::OFS_EP0_IN, 32'h0);
      host_u.send_setup();
    join
    chk("stall held", 32'h9, rdata);
    rdc(usb_ep0_pkg::OFS_EP0_IN, 32'h1, "deferred clear");
    wr(usb_ep0_pkg::OFS_EP0_IN, 32'h0);
    tok(2, 3'b000);
    wr(usb_ep0_pkg::OFS_EP0_IN, 32'h1);
    wr(usb_ep0_pkg::OFS_IRQ_STAT, 32'h7);
    wr(usb_ep0_pkg::OFS_CORE_CTRL, 32'h3);
    host_u.set_bus_reset(1'b1);
    repeat (5) @(posedge clock_i);
    chk("bus reset core_rst", 32'h1, {31'h0, core_rst});
    wr(usb_ep0_pkg::OFS_CORE_CTRL, 32'h1);
    rdc(usb_ep0_pkg::OFS_CORE_CTRL, 32'h3, "ctrl kept");
    rdc(usb_ep0_pkg::OFS_EP0_IN, 32'h0, "ep cleared");
    rdc(usb_ep0_pkg::OFS_IRQ_STAT, 32'h2, "bus reset flag");
    host_u.set_bus_reset(1'b0);
    repeat (5) @(posedge clock_i);
    chk("core_rst", 32'h0, {31'h0, core_rst});
    wr(usb_ep0_pkg::OFS_IRQ_STAT, 32'h7);
    // pll flags keep coming back until lock has settled
    wr(usb_ep0_pkg::OFS_PLL_CTRL, 32'h1);
    chk("pll_en", 32'h1, {31'h0, pll_en});
    wr(usb_ep0_pkg::OFS_PLL_STAT, 32'h0);
    repeat (5) @(posedge clock_i);
    rdc(usb_ep0_pkg::OFS_PLL_STAT, 32'h1, "pll flag");
    host_u.set_lock(1'b1);
    for (int i = 0; i < 60; i++)
    begin
      wr(usb_ep0_pkg::OFS_PLL_STAT, 32'h0);
      repeat (20) @(posedge clock_i);
      apb(1'b0, usb_ep0_pkg::OFS_PLL_STAT, 32'h0);
      if (rdata === 32'h0)
        break;
    end
    chk("pll settled", 32'h0, rdata);
    wr(usb_ep0_pkg::OFS_EP0_IN, 32'h1);
    wr(usb_ep0_pkg::OFS_CORE_CTRL, 32'h0);
    repeat (3) @(posedge clock_i);
    chk("core off", 32'h1, {31'h0, core_rst});
    rdc(usb_ep0_pkg::OFS_EP0_IN, 32'h0, "ep after core off");
    print_verdict();
  end
endmodule
